// >>> dv/ddr_burst_properties.sv
// checker for the burst memory interface port behaviour
`timescale 1ns/10ps
module ddr_burst_checker
   import ddr_burst_pkg::*;
(
   input wire logic              clk_in,              // system clock
   input wire logic              reset_n_in,          // sync reset, active low
   input wire logic              chip_select_n_in,    // select
   input wire logic              write_enable_n_in,   // write strobe
   input wire logic              refresh_n_in,        // refresh strobe
   input wire logic [DATA_W-1:0] data_out,            // read word
   input wire logic              data_oe_out,         // drive enable
   input wire logic              read_data_clock_out, // read clock
   input wire logic              read_valid_flag_out, // read word valid
   input wire logic [1:0]        burst_code_out,      // burst code
   input wire logic              write_overflow_out   // sticky drop flag
);
   logic [7:0] cfg_age; // cycles since config pins were shown
   logic [7:0] rd_age;  // cycles since read pins were shown
   logic [7:0] vrun;    // length of current valid run
   logic [7:0] still;   // cycles the read clock has not moved
   logic       rclk_q;  // read clock one cycle ago
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);
   // ages saturate so a long idle never wraps into a false match
   always_ff @(posedge clk_in) begin
      if (!reset_n_in || !(chip_select_n_in | write_enable_n_in | refresh_n_in)) cfg_age <= 8'h00;
      else if (cfg_age != 8'hff) cfg_age <= cfg_age + 8'h01;
   end
   always_ff @(posedge clk_in) begin
      if (!reset_n_in || (!chip_select_n_in && write_enable_n_in && refresh_n_in)) rd_age <= 8'h00;
      else if (rd_age != 8'hff) rd_age <= rd_age + 8'h01;
   end
   // run lengths of valid and of a stuck read clock
   always_ff @(posedge clk_in) begin
      vrun <= (!reset_n_in || !read_valid_flag_out) ? 8'h00 : vrun + 8'h01;
      rclk_q <= read_data_clock_out;
      still <= (!reset_n_in || read_data_clock_out != rclk_q) ? 8'h00 : still + 8'h01;
   end
   AST_RESET_QUIET: assert property (disable iff (1'b0) !reset_n_in |=> !data_oe_out && !read_valid_flag_out
      && burst_code_out == 2'h0 && !write_overflow_out && data_out == '0) else $error("outputs not quiet in reset");
   AST_CODE_LEGAL: assert property (burst_code_out != 2'h3) else $error("illegal burst code");
   AST_CODE_FROM_CFG: assert property ($changed(burst_code_out) |-> cfg_age < 8'h10)
      else $error("burst code moved without config");
   AST_OE_COVERS_VALID: assert property (read_valid_flag_out |-> data_oe_out) else $error("valid without drive");
   AST_VALID_MIN: assert property ($rose(read_valid_flag_out) |-> read_valid_flag_out[*8])
      else $error("read burst too short");
   AST_VALID_MAX: assert property (vrun <= 8'h20) else $error("read burst too long");
   AST_READ_LATENCY: assert property ($rose(data_oe_out) |-> rd_age >= 8'h0c && rd_age <= 8'h18)
      else $error("read data at wrong time");
   AST_OE_DROP: assert property ($fell(read_valid_flag_out) |-> !data_oe_out) else $error("drive held after burst");
   AST_READ_CLK_FREE: assert property (still < 8'h08) else $error("read clock stopped");
   AST_OVF_STICKY: assert property (write_overflow_out |=> write_overflow_out) else $error("overflow flag lost");
   cover property ($rose(read_valid_flag_out));
   cover property ($changed(burst_code_out));
   cover property ($fell(data_oe_out));
endmodule
bind ddr_burst_memory_interface ddr_burst_checker ddr_burst_checker_inst (.clk_in(clk_in), .reset_n_in(reset_n_in),
   .chip_select_n_in(chip_select_n_in), .write_enable_n_in(write_enable_n_in), .refresh_n_in(refresh_n_in),
   .data_out(data_out), .data_oe_out(data_oe_out), .read_data_clock_out(read_data_clock_out),
   .read_valid_flag_out(read_valid_flag_out), .burst_code_out(burst_code_out),
   .write_overflow_out(write_overflow_out));

// >>> dv/mem_ctrl_model.sv
// controller model: clocks, commands and write data toward the device
`timescale 1ns/10ps
module mem_ctrl_model
   import ddr_burst_pkg::*;
(
   input  wire logic         clk_in,    // system clock
   output logic              cclk_out,  // command clock
   output logic              wclk_out,  // write data clock
   output logic              cs_n_out,  // select, active low
   output logic              we_n_out,  // write, active low
   output logic              ref_n_out, // refresh, active low
   output logic [ADDR_W-1:0] addr_out,  // address or config word
   output logic [BANK_W-1:0] bank_out,  // bank
   output logic [DATA_W-1:0] wdata_out, // write word
   output logic              mask_out   // word mask
);
   // pins idle; data clock stands still outside write bursts
   initial begin
      {wclk_out, cs_n_out, we_n_out, ref_n_out, mask_out} = 5'h0e;
      addr_out = '0;
      bank_out = '0;
      wdata_out = '0;
   end
   // command clock runs free, 8 system clocks a period
   initial begin
      cclk_out = 1'b0;
      forever begin
         repeat (4) @(posedge clk_in);
         #1 cclk_out = ~cclk_out;
      end
   end
   // pins held from fall to fall so the rise sits mid-window
   task automatic issue(input logic [2:0] cmd, input logic [ADDR_W-1:0] a, input logic [BANK_W-1:0] b);
      @(negedge cclk_out);
      {cs_n_out, we_n_out, ref_n_out} = cmd; // sampled only at the rise
      addr_out = a;
      bank_out = b;
      @(negedge cclk_out);
      {cs_n_out, we_n_out, ref_n_out} = 3'h7;
      addr_out = ~a; // released lines show junk, not the old value
      bank_out = ~b;
   endtask
   // one word per data clock edge, rise and fall alike
   task automatic write_words(input logic [DATA_W-1:0] w [8], input logic [7:0] m, input int n);
      for (int k = 0; k < n; k++) begin
         wdata_out = w[k];
         mask_out = m[k];
         repeat (4) @(posedge clk_in);
         #1 wclk_out = ~wclk_out; // both edges carry data
         repeat (4) @(posedge clk_in);
         #1;
      end
      wdata_out = ~w[n-1]; // exactly n words sent
      mask_out = 1'b0;
   endtask
endmodule

// >>> dv/testbench.sv
// self-checking bench for the burst memory interface
`timescale 1ns/10ps
module testbench;
   import ddr_burst_pkg::*;
   logic clk_in, reset_n_in, cclk, wclk, cs_n, we_n, ref_n, mask, oe, rclk, valid, ovf;
   logic [ADDR_W-1:0] addr;   // address pins
   logic [BANK_W-1:0] bank;   // bank pins
   logic [DATA_W-1:0] wdata;  // write pins
   logic [DATA_W-1:0] rdata;  // read pins
   logic [1:0]        code;   // burst code
   logic [DATA_W-1:0] wa [8]; // first pattern
   logic [DATA_W-1:0] wb [8]; // second pattern
   logic [DATA_W-1:0] got [8];// captured words
   int miscompares = 0;
   int tests_run = 0;
   int cycles = 0;
   ddr_burst_memory_interface ddr_burst_memory_interface_inst (.clk_in(clk_in), .reset_n_in(reset_n_in),
      .enable_in(1'b1), .command_clock_in(cclk), .write_data_clock_in(wclk), .chip_select_n_in(cs_n),
      .write_enable_n_in(we_n), .refresh_n_in(ref_n), .addr_in(addr), .bank_in(bank), .data_in(wdata),
      .write_byte_mask_in(mask), .data_out(rdata), .data_oe_out(oe), .read_data_clock_out(rclk),
      .read_valid_flag_out(valid), .burst_code_out(code), .write_overflow_out(ovf));
   mem_ctrl_model mem_ctrl_model_inst (.clk_in(clk_in), .cclk_out(cclk), .wclk_out(wclk), .cs_n_out(cs_n),
      .we_n_out(we_n), .ref_n_out(ref_n), .addr_out(addr), .bank_out(bank), .wdata_out(wdata), .mask_out(mask));
   task automatic check(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch at %0t: got %0h expected %0h", $time, g, e);
      end
   endtask
   task automatic conclude();
      $display("compares %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // config word carries the code in address bits 4:3
   task automatic set_len(input logic [1:0] c);
      mem_ctrl_model_inst.issue(3'h0, {16'h0, c, 3'h0}, 3'h0);
      repeat (16) @(posedge clk_in);
      #1;
   endtask
   task automatic wr(input logic [2:0] b, input logic [5:0] r, input logic [3:0] c, input int n,
                     input logic [DATA_W-1:0] w [8], input logic [7:0] m);
      mem_ctrl_model_inst.issue(3'h1, {11'h0, r, c}, b);
      mem_ctrl_model_inst.write_words(w, m, n);
      repeat (8) @(posedge clk_in);
      #1;
   endtask
   // each word stands 4 clocks; sample one clock into each
   task automatic rd(input logic [2:0] b, input logic [5:0] r, input logic [3:0] c, input int n,
                     input logic [DATA_W-1:0] e [8]);
      int nv;
      logic pr;  // read clock one clock earlier
      nv = 0;
      pr = 1'b0;
      mem_ctrl_model_inst.issue(3'h3, {11'h0, r, c}, b);
      for (int k = 0; k < 200; k++) begin
         @(posedge clk_in);
         #1;
         if (valid === 1'b1) begin
            if (nv % 4 == 0) check({oe, rclk ^ pr}, 2'h3);
            if (nv % 4 == 1 && nv < 32) got[nv/4] = rdata;
            nv++;
         end else if (nv > 0) break;
         pr = rclk;
      end
      check(nv, 4 * n); // two words per command cycle
      for (int k = 0; k < n; k++) check(got[k], e[k]);
   endtask
   task automatic test_lengths();
      for (int c = 0; c < 3; c++) begin
         set_len(2'(c));
         check(code, c);
         for (int k = 0; k < 8; k++) wa[k] = DATA_W'(c * 64 + k * 9 + 1);
         wr(3'h1, 6'h03, 4'h0, 2 << c, wa, 8'h00);
         rd(3'h1, 6'h03, 4'h0, 2 << c, wa);
      end
      set_len(2'h3);
      check(code, 2'h2); // unused code is ignored
   endtask
   // same place in two banks, a refresh between, then a masked word
   task automatic test_banks_mask();
      set_len(2'h0);
      for (int k = 0; k < 8; k++) wb[k] = DATA_W'(9'h1a5 ^ k);
      wr(3'h0, 6'h09, 4'h2, 2, wa, 8'h00);
      wr(3'h7, 6'h09, 4'h2, 2, wb, 8'h00);
      mem_ctrl_model_inst.issue(3'h2, '0, 3'h0);
      rd(3'h0, 6'h09, 4'h2, 2, wa);
      rd(3'h7, 6'h09, 4'h2, 2, wb);
      wr(3'h0, 6'h09, 4'h2, 2, wb, 8'h02);
      got = wb;
      got[1] = wa[1];
      wb = got;
      rd(3'h0, 6'h09, 4'h2, 2, wb);
      check(ovf, 1'b0);
   endtask
   // a four word burst ignores the lowest column bit: columns 5 and 4 share a base
   task automatic test_align();
      set_len(2'h1);
      wr(3'h2, 6'h05, 4'h5, 4, wa, 8'h00);
      rd(3'h2, 6'h05, 4'h4, 4, wa);
   endtask
   initial begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end
   // hang guard, well above the thousand or so cycles expected
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         conclude();
      end
   end
   initial begin
      reset_n_in = 1'b0;
      repeat (6) @(posedge clk_in);
      #1 reset_n_in = 1'b1;
      repeat (8) @(posedge clk_in);
      #1;
      test_lengths();
      test_banks_mask();
      test_align();
      conclude();
   end
endmodule

// >>> verilog/ddr_burst_memory_interface.sv
// device side of a ddr burst memory: command decode, banks, read and write bursts
`timescale 1ns/10ps
module ddr_burst_memory_interface
   import ddr_burst_pkg::*;
(
   input  wire logic              clk_in,              // system clock, 10 MHz
   input  wire logic              reset_n_in,          // sync reset, active low
   input  wire logic              enable_in,           // clock enable, freezes all state
   input  wire logic              command_clock_in,    // command clock pin
   input  wire logic              write_data_clock_in, // write data clock pin
   input  wire logic              chip_select_n_in,    // command select, active low
   input  wire logic              write_enable_n_in,   // write command, active low
   input  wire logic              refresh_n_in,        // refresh command, active low
   input  wire logic [ADDR_W-1:0] addr_in,             // address or config word
   input  wire logic [BANK_W-1:0] bank_in,             // bank select
   input  wire logic [DATA_W-1:0] data_in,             // shared data pins, input side
   input  wire logic              write_byte_mask_in,  // masks a write word when high
   output logic      [DATA_W-1:0] data_out,            // shared data pins, output side
   output logic                   data_oe_out,         // high while device drives data
   output logic                   read_data_clock_out, // free-running read data clock
   output logic                   read_valid_flag_out, // read word on data_out valid
   output logic      [1:0]        burst_code_out,      // programmed burst length code
   output logic                   write_overflow_out   // sticky: write word dropped
);
   // pin synchronisers
   // every pin is sampled by the system clock, so a pin must hold for at least
   // three system clocks around a link clock edge to be taken cleanly
   logic [1:0] ck_sync;                                 // command clock sync pair
   logic [1:0] dk_sync;                                 // data clock sync pair
   logic       ck_last;                                 // previous synced command clock
   logic       dk_last;                                 // previous synced data clock
   logic [2:0] ctl_s1, ctl_s2;                          // control sync stages
   logic [ADDR_W-1:0] addr_s1, addr_s2;                 // address sync stages
   logic [BANK_W-1:0] bank_s1, bank_s2;                 // bank sync stages
   logic [DATA_W:0]   dq_s1, dq_s2;                     // data plus mask sync stages

   // two flops on every pin; only the second stage is read by logic
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         ck_sync <= '0;
         dk_sync <= '0;
         ctl_s1  <= 3'h7;
         ctl_s2  <= 3'h7;
         addr_s1 <= '0;
         addr_s2 <= '0;
         bank_s1 <= '0;
         bank_s2 <= '0;
         dq_s1   <= '0;
         dq_s2   <= '0;
      end else if (enable_in) begin
         ck_sync <= {ck_sync[0], command_clock_in};
         dk_sync <= {dk_sync[0], write_data_clock_in};
         ctl_s1  <= {chip_select_n_in, write_enable_n_in, refresh_n_in};
         ctl_s2  <= ctl_s1;
         addr_s1 <= addr_in;
         addr_s2 <= addr_s1;
         bank_s1 <= bank_in;
         bank_s2 <= bank_s1;
         dq_s1   <= {write_byte_mask_in, data_in};
         dq_s2   <= dq_s1;
      end
   end

   // edge memory for the synced clocks
   // cleared to the idle low level of the pins so release makes no false edge
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         ck_last <= 1'b0;
         dk_last <= 1'b0;
      end else if (enable_in) begin
         ck_last <= ck_sync[1];
         dk_last <= dk_sync[1];
      end
   end

   // edges are found behind the second sync stage; control, address and data pass
   // the same two stages, so each lines up with the clock edge it belongs to
   logic ck_rise;                                       // command clock rising edge
   logic ck_fall;                                       // command clock falling edge
   logic dk_edge;                                       // either data clock edge
   assign ck_rise = ck_sync[1] && !ck_last;
   assign ck_fall = !ck_sync[1] && ck_last;
   assign dk_edge = dk_sync[1] ^ dk_last;

   // command decode
   // control counts only on a command clock rise; select high means no command
   // select low: config, write, refresh or read by the two strobes
   logic cmd_sel, cmd_write, cmd_read, cmd_refresh, cmd_config;
   assign cmd_sel     = ck_rise && !ctl_s2[2];
   assign cmd_config  = cmd_sel && !ctl_s2[1] && !ctl_s2[0];
   assign cmd_write   = cmd_sel && !ctl_s2[1] &&  ctl_s2[0];
   assign cmd_refresh = cmd_sel &&  ctl_s2[1] && !ctl_s2[0];
   assign cmd_read    = cmd_sel &&  ctl_s2[1] &&  ctl_s2[0];

   // configuration
   logic [1:0]        burst_code;                       // programmed length code
   logic [BCNT_W-1:0] burst_len;                        // words per burst
   logic [1:0]        new_code;                         // field from address

   assign new_code = addr_s2[BL_FIELD_LO +: 2];

   // config command loads the length field; an invalid code is ignored
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         burst_code <= BL_RESET;
      end else if (enable_in && cmd_config) begin
         if (new_code == BL_CODE_2 || new_code == BL_CODE_4 || new_code == BL_CODE_8) begin
            burst_code <= new_code;
         end
      end
   end

   // words per burst follow the stored code; the default keeps two words
   always_comb begin
      case (burst_code)
         BL_CODE_4: burst_len = WORDS_4;
         BL_CODE_8: burst_len = WORDS_8;
         default:   burst_len = WORDS_2;
      endcase
   end

   // address split
   // longer bursts drop low column bits: the burst counter supplies them
   // at two words the whole column is used, so a burst may start anywhere
   logic [COL_W-1:0] col_base;                          // start column of burst
   always_comb begin
      case (burst_code)
         BL_CODE_4: col_base = {addr_s2[COL_W-1:1], 1'b0};
         BL_CODE_8: col_base = {addr_s2[COL_W-1:2], 2'h0};
         default:   col_base = addr_s2[COL_W-1:0];
      endcase
   end

   // memory array, eight banks
   // modelled small: a few row bits per bank and no array timing of its own
   logic [DATA_W-1:0] mem [MEM_WORDS];                  // array words
   logic [ROW_W-1:0]  refresh_row [BANKS];              // per-bank internal row counters
   logic [MEM_AW-1:0] burst_base;                       // bank/row/column of burst
   logic [BCNT_W-1:0] beat;                             // words done in burst
   logic [MEM_AW-1:0] beat_addr;                        // array address of current word

   assign beat_addr = burst_base + MEM_AW'(beat);

   // each bank keeps its own refresh row; controller supplies none
   // the counters only advance, as there is no stored charge to restore here
   genvar gb;
   generate
      for (gb = 0; gb < BANKS; gb++) begin : g_bank
         always_ff @(posedge clk_in) begin
            if (!reset_n_in) begin
               refresh_row[gb] <= '0;
            end else if (enable_in && cmd_refresh && bank_s2 == BANK_W'(gb)) begin
               refresh_row[gb] <= refresh_row[gb] + 1'b1;
            end
         end
      end
   endgenerate

   // write path buffer
   // decouples capture from the array write; words arrive every few clocks and
   // drain one per clock, so it fills only if the data clock runs far too fast
   logic              wbuf_ready;                       // room in buffer
   logic [DATA_W:0]   wbuf_data;                        // head word plus mask
   logic              wbuf_valid;                       // head present
   logic              wbuf_pop;                         // drain strobe
   logic              wr_capture;                       // a write word taken

   word_fifo #(.WIDTH(DATA_W + 1), .DEPTH(FIFO_DEPTH)) u_wbuf (
      .clk_in         (clk_in),
      .reset_n_in     (reset_n_in),
      .enable_in      (enable_in),
      .push_data_in   (dq_s2),
      .push_valid_in  (wr_capture),
      .push_ready_out (wbuf_ready),
      .pop_data_out   (wbuf_data),
      .pop_valid_out  (wbuf_valid),
      .pop_ready_in   (wbuf_pop)
   );

   // transfer sequencer
   // one burst at a time: read and write commands during a burst are dropped on purpose, which
   // keeps the sequencer small at the cost of back-to-back bursts
   xfer_state_e       state;                            // sequencer state
   logic [BCNT_W-1:0] taken;                            // write words captured
   logic [1:0]        lat_cnt;                          // read latency count

   // write words arrive on both data clock edges, two per data clock cycle
   assign wr_capture = (state == ST_WRITE) && dk_edge && (taken < burst_len);
   // drain writes into the array one per system clock
   assign wbuf_pop   = wbuf_valid && (state == ST_WRITE);

   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         state      <= ST_IDLE;
         burst_base <= '0;
         beat       <= '0;
         taken      <= '0;
         lat_cnt    <= '0;
      end else if (enable_in) begin
         case (state)
            ST_IDLE: begin
               beat  <= '0;
               taken <= '0;
               burst_base <= {bank_s2, addr_s2[COL_W +: ROW_W], col_base};
               if (cmd_write) begin
                  state <= ST_WRITE;
               end else if (cmd_read) begin
                  state   <= ST_READ_WAIT;
                  lat_cnt <= '0;
               end
            end
            ST_WRITE: begin
               if (wr_capture) begin
                  taken <= taken + 1'b1;
               end
               if (wbuf_pop) begin
                  beat <= beat + 1'b1;
                  if (beat + 1'b1 == burst_len) begin
                     state <= ST_IDLE;
                  end
               end
            end
            ST_READ_WAIT: begin
               if (ck_rise) begin
                  lat_cnt <= lat_cnt + 1'b1;
                  if (lat_cnt == 2'(READ_LAT - 1)) begin
                     state <= ST_READ;
                  end
               end
            end
            ST_READ: begin
               // a word goes out on each read clock edge
               if (ck_rise || ck_fall) begin
                  beat <= beat + 1'b1;
                  if (beat + 1'b1 == burst_len) begin
                     state <= ST_IDLE;
                  end
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // array write with mask; a masked word leaves the location unchanged
   // the array has no reset, so a word reads unknown until it is written
   always_ff @(posedge clk_in) begin
      if (enable_in && reset_n_in && wbuf_pop && !wbuf_data[DATA_W]) begin
         mem[beat_addr] <= wbuf_data[DATA_W-1:0];
      end
   end

   // sticky overflow: a write word arrived while the buffer was full
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         write_overflow_out <= 1'b0;
      end else if (enable_in && wr_capture && !wbuf_ready) begin
         write_overflow_out <= 1'b1;
      end
   end

   // read output, aligned to read clock
   // read clock follows the command clock edges and never stops
   // data and read clock leave from the same edge, so they stay aligned even
   // though both trail the command clock pin by the synchroniser delay
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         read_data_clock_out <= 1'b0;
         data_out            <= '0;
         data_oe_out         <= 1'b0;
         read_valid_flag_out <= 1'b0;
      end else if (enable_in) begin
         read_data_clock_out <= ck_sync[1];
         if (state == ST_READ && (ck_rise || ck_fall)) begin
            data_out            <= mem[beat_addr];
            data_oe_out         <= 1'b1;
            read_valid_flag_out <= 1'b1;
         end else if (state != ST_READ && (ck_rise || ck_fall)) begin
            data_oe_out         <= 1'b0;
            read_valid_flag_out <= 1'b0;
         end
      end
   end

   // programmed code shown on a pin, straight from a flop
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         burst_code_out <= BL_RESET;
      end else if (enable_in) begin
         burst_code_out <= burst_code;
      end
   end
endmodule

// >>> verilog/ddr_burst_pkg.sv
// constants and types shared by the burst memory interface
package ddr_burst_pkg;
   localparam int DATA_W      = 9;              // data word width
   localparam int ADDR_W      = 21;             // address inputs
   localparam int BANK_W      = 3;              // bank select width
   localparam int BANKS       = 8;              // independent banks
   localparam int ROW_W       = 6;              // modelled row bits per bank
   localparam int COL_W       = 4;              // full column width at two words
   localparam int BURST_MAX   = 8;              // longest burst
   localparam int BCNT_W      = 4;              // burst counter width
   localparam int FIFO_DEPTH  = 4;              // write data buffer depth
   localparam int READ_LAT    = 2;              // command-clock cycles before read data
   localparam int MEM_WORDS   = BANKS * (1 << ROW_W) * (1 << COL_W);
   localparam int MEM_AW      = BANK_W + ROW_W + COL_W;
   // burst length field codes in the config word
   localparam logic [1:0] BL_CODE_2   = 2'h0;
   localparam logic [1:0] BL_CODE_4   = 2'h1;
   localparam logic [1:0] BL_CODE_8   = 2'h2;
   localparam int         BL_FIELD_LO = 3;      // config field position
   localparam logic [1:0] BL_RESET    = BL_CODE_2;
   localparam logic [BCNT_W-1:0] WORDS_2 = 4'h2;
   localparam logic [BCNT_W-1:0] WORDS_4 = 4'h4;
   localparam logic [BCNT_W-1:0] WORDS_8 = 4'h8;
   typedef enum logic [1:0] {CMD_NOP, CMD_WRITE, CMD_READ, CMD_REFRESH} unused_t;
   typedef enum {ST_IDLE, ST_WRITE, ST_READ_WAIT, ST_READ} xfer_state_e;
endpackage

// >>> verilog/word_fifo.sv
// small valid/ready fifo holding captured write words
`timescale 1ns/10ps
module word_fifo #(
   parameter int WIDTH = 9,                      // word width
   parameter int DEPTH = 4                       // entries
) (
   input  wire logic             clk_in,         // system clock
   input  wire logic             reset_n_in,     // sync reset, active low
   input  wire logic             enable_in,      // clock enable
   input  wire logic [WIDTH-1:0] push_data_in,   // word in
   input  wire logic             push_valid_in,  // word offered
   output logic                  push_ready_out, // room available
   output logic      [WIDTH-1:0] pop_data_out,   // head word
   output logic                  pop_valid_out,  // head present
   input  wire logic             pop_ready_in    // drain accepts
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] store [DEPTH];              // entries
   logic [PW-1:0]    wr_ptr;                     // write index
   logic [PW-1:0]    rd_ptr;                     // read index
   logic [PW:0]      count;                      // occupancy
   logic             do_push;                    // accepted push
   logic             do_pop;                     // accepted pop

   assign push_ready_out = (count < (PW+1)'(DEPTH));
   assign pop_valid_out  = (count != '0);
   assign pop_data_out   = store[rd_ptr];
   assign do_push = push_valid_in && push_ready_out;
   assign do_pop  = pop_valid_out && pop_ready_in;

   // storage and pointers; a push when full is refused, so nothing is overwritten
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else if (enable_in) begin
         if (do_push) begin
            store[wr_ptr] <= push_data_in;
            wr_ptr        <= (wr_ptr == PW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
         end
         if (do_pop) begin
            rd_ptr <= (rd_ptr == PW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
         end
         count <= count + (PW+1)'(do_push) - (PW+1)'(do_pop);
      end
   end
endmodule
